// ### hdl/xae_core.sv
`timescale 1ns/1ps
`include "xae_consts.svh"

module xae_core (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   // Clears
   input  wire logic              panel_clear_b,
   input  wire logic              clear_all_flags_op,
   // Instruction fetch from the host
   input  wire logic              fetch_strobe,
   input  wire logic [11:0]       memory_word_buffer,
   input  wire xae_pkg::xae_work_t work_in,
   output logic                   claim,
   // Second word from the host
   output logic                   opnd_req,
   output logic                   opnd_is_addr,
   input  wire logic              opnd_strobe,
   input  wire logic [11:0]       opnd_word,
   // Completion and results
   output logic                   busy,
   output logic                   done_strobe,
   output xae_pkg::xae_work_t     work_out,
   output logic                   greater_flag,
   output logic                   mode_ext,
   output logic [4:0]             shift_tally
);
   import xae_pkg::*;

   // ***********************************************************************
   // State
   // ***********************************************************************
   xae_state_t  state_reg,  state_next;
   logic [3:0]  op_latch_reg, op_latch_next;   // extension_op_latch
   logic        mode_reg,   mode_next;
   logic [4:0]  tally_reg,  tally_next;
   xae_work_t   work_reg,   work_next;
   logic        gt_reg,     gt_next;
   logic [11:0] opnd_reg,   opnd_next;
   logic        first_reg,  first_next;
   logic        done_reg,   done_next;
   logic        pclr_meta_reg;
   logic        pclr_sync_reg;
   // The working chain is copied in at the fetch and handed back at done
   // Mode and greater flag live across instructions; mode words, extended right shifts and clears change them

   // ***********************************************************************
   // Decode
   // ***********************************************************************
   logic [2:0]  code;
   logic [2:0]  fetch_code;
   logic        is_ext_word;
   logic        clr_mode;
   logic [12:0] mul_sum;
   logic [12:0] div_rem;
   logic        div_fits;
   logic [23:0] chain;

   // Host bit 0 is index 11 here, so field positions count from the right
   // The decode looks at the live buffer, not a copy, during the fetch cycle
   // Recognise operate-class words with both marker bits set
   assign is_ext_word = (memory_word_buffer[`XAE_OPC_HI:`XAE_OPC_LO] == `XAE_OPC_OPERATE)
                      && memory_word_buffer[`XAE_BIT_GROUP3]
                      && memory_word_buffer[`XAE_BIT_LAST];
   assign fetch_code  = memory_word_buffer[`XAE_CODE_HI:`XAE_CODE_LO];
   assign code        = op_latch_reg[2:0];
   assign clr_mode    = !pclr_sync_reg || clear_all_flags_op;

   // Datapath helpers
   // mul_sum is one shift-add step; the carry out lands in the top primary bit
   // div_rem is the partial remainder with the next dividend bit shifted in
   // chain is the 24-bit value tested by normalize
   assign mul_sum  = {1'b0, work_reg.prim} + (work_reg.low[0] ? {1'b0, opnd_reg} : 13'h0000);
   assign div_rem  = {work_reg.prim, work_reg.low[11]};
   assign div_fits = div_rem >= {1'b0, opnd_reg};
   assign chain    = {work_reg.prim, work_reg.low};

   // ***********************************************************************
   // Handshake and result outputs
   // ***********************************************************************
   // Claim and busy are combinational so the hold-off is seen at once;
   // a registered claim would let a second fetch slip in behind the first
   // Handshake outputs
   assign claim        = fetch_strobe && is_ext_word && (state_reg == XAE_IDLE);
   assign busy         = state_reg != XAE_IDLE;
   assign opnd_req     = state_reg == XAE_WAIT_OPND;
   assign opnd_is_addr = mode_reg && ((code == `XAE_CODE_MUL) || (code == `XAE_CODE_DIV));

   // Registered data outputs
   assign done_strobe  = done_reg;
   assign work_out     = work_reg;
   assign greater_flag = mode_reg ? gt_reg : 1'b0;
   assign mode_ext     = mode_reg;
   assign shift_tally  = tally_reg;

   // ***********************************************************************
   // Next-state logic
   // ***********************************************************************
   always_comb begin
      state_next    = state_reg;
      op_latch_next = op_latch_reg;
      mode_next     = mode_reg;
      tally_next    = tally_reg;
      work_next     = work_reg;
      gt_next       = gt_reg;
      opnd_next     = opnd_reg;
      first_next    = first_reg;
      done_next     = 1'b0;
      case (state_reg)
         XAE_IDLE: begin
            // Accept a fetch only while idle; other words pass untouched
            if (claim) begin
               op_latch_next = {memory_word_buffer[`XAE_BIT_SCA],
                                fetch_code};
               work_next     = work_in;
               if (memory_word_buffer == `XAE_WORD_TO_EXT) begin
                  mode_next = `XAE_MODE_EXT;
                  done_next = 1'b1;
               end else if (memory_word_buffer == `XAE_WORD_TO_COMPAT) begin
                  mode_next = `XAE_MODE_COMPAT;
                  done_next = 1'b1;
               end else begin
                  case (fetch_code)
                     `XAE_CODE_NONE: begin
                        // Tally merged into the low primary bits
                        if (memory_word_buffer[`XAE_BIT_SCA] && !mode_reg) begin
                           work_next.prim = work_in.prim | {7'h00, tally_reg};
                        end
                        done_next = 1'b1;
                     end
                     `XAE_CODE_TALLY: begin
                        if (mode_reg) begin
                           // Tally taken from the primary register, which then clears
                           tally_next     = work_in.prim[4:0];
                           work_next.prim = 12'h000;
                           done_next      = 1'b1;
                        end else begin
                           state_next = XAE_WAIT_OPND;
                        end
                     end
                     `XAE_CODE_NORM: begin
                        tally_next = `XAE_TALLY_ZERO;
                        state_next = XAE_RUN;
                     end
                     default: begin
                        state_next = XAE_WAIT_OPND;
                     end
                  endcase
               end
            end
         end
         XAE_WAIT_OPND: begin
            // Operand arrives; every counted op except normalize loads its tally here
            if (opnd_strobe) begin
               opnd_next  = opnd_word;
               first_next = 1'b1;
               state_next = XAE_RUN;
               case (code)
                  `XAE_CODE_TALLY: begin
                     tally_next = ~opnd_word[4:0];
                     state_next = XAE_IDLE;
                     done_next  = 1'b1;
                  end
                  `XAE_CODE_MUL,
                  `XAE_CODE_DIV: begin
                     tally_next = `XAE_MUL_STEPS;
                  end
                  `XAE_CODE_SHL: begin
                     tally_next = opnd_word[4:0];
                  end
                  `XAE_CODE_ASR: begin
                     tally_next     = opnd_word[4:0];
                     work_next.link = work_reg.prim[11];
                  end
                  `XAE_CODE_LSR: begin
                     tally_next     = opnd_word[4:0];
                     work_next.link = 1'b0;
                  end
                  default: begin
                     state_next = XAE_IDLE;
                     done_next  = 1'b1;
                  end
               endcase
            end
         end
         XAE_RUN: begin
            // One step per clock; the tally decides the end, save a divide overflow or a normalize that meets differing top bits or the stop pattern
            first_next = 1'b0;
            case (code)
               `XAE_CODE_MUL: begin
                  if (tally_reg == `XAE_TALLY_ZERO) begin
                     // Twelve steps done: product complete
                     work_next.link = 1'b0;
                     state_next     = XAE_IDLE;
                     done_next      = 1'b1;
                  end else begin
                     // Shift-add; a prior primary value rides into the product
                     work_next.prim = mul_sum[12:1];
                     work_next.low  = {mul_sum[0], work_reg.low[11:1]};
                     tally_next     = tally_reg - 5'h01;
                  end
               end
               `XAE_CODE_DIV: begin
                  // Overflow is judged on the first trial only
                  if (first_reg && (work_reg.prim >= opnd_reg)) begin
                     work_next.link = 1'b1;
                     state_next     = XAE_IDLE;
                     done_next      = 1'b1;
                  end else if (tally_reg == `XAE_TALLY_ZERO) begin
                     work_next.link = 1'b0;
                     state_next     = XAE_IDLE;
                     done_next      = 1'b1;
                  end else begin
                     // Restoring step: remainder in primary, quotient in low half
                     work_next.prim = div_fits ? 12'(div_rem - {1'b0, opnd_reg})
                                               : div_rem[11:0];
                     work_next.low  = {work_reg.low[10:0], div_fits};
                     tally_next     = tally_reg - 5'h01;
                  end
               end
               `XAE_CODE_NORM: begin
                  // The tally limit guards a zero value that never normalizes
                  if ((work_reg.prim[11] != work_reg.prim[10])
                      || (chain == `XAE_NORM_STOP)
                      || (tally_reg == `XAE_TALLY_MAX)) begin
                     if (mode_reg && (chain == `XAE_NORM_HALF)) begin
                        work_next.prim = 12'h000;
                     end
                     state_next = XAE_IDLE;
                     done_next  = 1'b1;
                  end else begin
                     work_next  = {work_reg.prim[11], work_reg.prim[10:0],
                                   work_reg.low[11], work_reg.low[10:0], 1'b0};
                     tally_next = tally_reg + 5'h01;
                  end
               end
               default: begin
                  // Shifts: compatible mode runs count plus one, extended runs count
                  if (mode_reg && (tally_reg == `XAE_TALLY_ZERO)) begin
                     state_next = XAE_IDLE;
                     done_next  = 1'b1;
                  end else begin
                     if (code == `XAE_CODE_SHL) begin
                        work_next = {work_reg.prim[11], work_reg.prim[10:0],
                                     work_reg.low[11], work_reg.low[10:0],
                                     1'b0};
                     end else begin
                        work_next.prim = {work_reg.link, work_reg.prim[11:1]};
                        work_next.low  = {work_reg.prim[0], work_reg.low[11:1]};
                        gt_next        = mode_reg ? work_reg.low[0] : gt_reg;
                     end
                     if (!mode_reg && (tally_reg == `XAE_TALLY_ZERO)) begin
                        state_next = XAE_IDLE;
                        done_next  = 1'b1;
                     end else begin
                        tally_next = tally_reg - 5'h01;
                     end
                  end
               end
            endcase
         end
         default: begin
            state_next = XAE_IDLE;
         end
      endcase
      // Panel clear or clear-all-flags forces compatible mode
      if (clr_mode) begin
         mode_next = `XAE_MODE_COMPAT;
         gt_next   = 1'b0;
      end
      // Panel clear abandons a running operation with no completion pulse
      if (!pclr_sync_reg) begin
         state_next = XAE_IDLE;
      end
   end

   // ***********************************************************************
   // Registers
   // ***********************************************************************
   // Synchronous reset only; the power-up clear arrives on rst_b
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_reg     <= XAE_IDLE;
         op_latch_reg  <= 4'h0;
         mode_reg      <= `XAE_MODE_COMPAT;
         tally_reg     <= `XAE_TALLY_ZERO;
         work_reg      <= '0;
         gt_reg        <= 1'b0;
         opnd_reg      <= 12'h000;
         first_reg     <= 1'b0;
         done_reg      <= 1'b0;
      end else begin
         state_reg     <= state_next;
         op_latch_reg  <= op_latch_next;
         mode_reg      <= mode_next;
         tally_reg     <= tally_next;
         work_reg      <= work_next;
         gt_reg        <= gt_next;
         opnd_reg      <= opnd_next;
         first_reg     <= first_next;
         done_reg      <= done_next;
      end
   end

   // ***********************************************************************
   // Panel clear synchroniser
   // ***********************************************************************
   // The pin is asynchronous; only the second flop feeds the logic,
   // which costs two cycles of latency before the clear takes effect
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pclr_meta_reg <= 1'b1;
         pclr_sync_reg <= 1'b1;
      end else begin
         pclr_meta_reg <= panel_clear_b;
         pclr_sync_reg <= pclr_meta_reg;
      end
   end

endmodule // xae_core

// ### hdl/xae_consts.svh
`ifndef XAE_CONSTS_SVH
`define XAE_CONSTS_SVH

// ***********************************************************************
// Word layout and decode
// ***********************************************************************
`define XAE_OPC_OPERATE    3'h7
`define XAE_OPC_HI         11
`define XAE_OPC_LO         9
`define XAE_BIT_GROUP3     8
`define XAE_BIT_LAST       0
`define XAE_BIT_SCA        5
`define XAE_CODE_HI        3
`define XAE_CODE_LO        1
`define XAE_WORD_TO_EXT    12'hF19
`define XAE_WORD_TO_COMPAT 12'hF27

// ***********************************************************************
// Instruction codes held in the low three latch bits
// ***********************************************************************
`define XAE_CODE_NONE      3'h0
`define XAE_CODE_TALLY     3'h1
`define XAE_CODE_MUL       3'h2
`define XAE_CODE_DIV       3'h3
`define XAE_CODE_NORM      3'h4
`define XAE_CODE_SHL       3'h5
`define XAE_CODE_ASR       3'h6
`define XAE_CODE_LSR       3'h7

// ***********************************************************************
// Counts and patterns
// ***********************************************************************
`define XAE_MUL_STEPS      5'h0C
`define XAE_TALLY_MAX      5'h1F
`define XAE_TALLY_ZERO     5'h00
`define XAE_NORM_STOP      24'hC00000
`define XAE_NORM_HALF      24'h800000
`define XAE_MODE_COMPAT    1'b0
`define XAE_MODE_EXT       1'b1

`endif

// ### hdl/xae_pkg.sv
package xae_pkg;

   // Carry, primary and low-half chain as one carrier
   typedef struct packed {
      logic        link;
      logic [11:0] prim;
      logic [11:0] low;
   } xae_work_t;

   // Sequencer states
   typedef enum logic [1:0] {
      XAE_IDLE,
      XAE_WAIT_OPND,
      XAE_RUN
   } xae_state_t;

endpackage

// ### dv/xae_core_props.sv
`timescale 1ns/1ps
// ****************************
// Port checks of the core
// ****************************
module xae_core_props (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_b,
   // Host side
   input wire logic        clear_all_flags_op,
   input wire logic        fetch_strobe,
   input wire logic [11:0] memory_word_buffer,
   input wire logic        opnd_strobe,
   // Core side
   input wire logic        claim,
   input wire logic        opnd_req,
   input wire logic        opnd_is_addr,
   input wire logic        busy,
   input wire logic        done_strobe,
   input wire logic        greater_flag,
   input wire logic        mode_ext
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Decode, hold-off, completion, operand and mode checks
   property p_claim_dec;
      claim |-> fetch_strobe && !busy && memory_word_buffer[11:9] == 3'h7
         && memory_word_buffer[8] && memory_word_buffer[0];
   endproperty
   property p_busy_claim;
      busy |-> !claim;
   endproperty
   property p_busy_start;
      $rose(busy) |-> $past(claim);
   endproperty
   property p_busy_end;
      $rose(busy) |-> ##[1:120] !busy;
   endproperty
   property p_done_end;
      $fell(busy) |-> done_strobe;
   endproperty
   property p_done_pulse;
      done_strobe |=> !done_strobe;
   endproperty
   property p_opnd_hold;
      opnd_req && !opnd_strobe |=> opnd_req;
   endproperty
   property p_addr_mode;
      opnd_is_addr |-> mode_ext;
   endproperty
   property p_caf;
      clear_all_flags_op |=> !mode_ext && !greater_flag;
   endproperty
   property p_compat_gt;
      !mode_ext |-> !greater_flag;
   endproperty
   property p_to_extended_mode_op;
      claim && memory_word_buffer == 12'hF19 && !clear_all_flags_op |-> ##[1:2] mode_ext;
   endproperty
   a_claim_dec: assert property (p_claim_dec) else $error("claim on foreign word");
   a_busy_claim: assert property (p_busy_claim) else $error("claim while busy");
   a_busy_start: assert property (p_busy_start) else $error("busy without claim");
   a_busy_end: assert property (p_busy_end) else $error("operation never ends");
   a_done_end: assert property (p_done_end) else $error("busy fell without done");
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   a_opnd_hold: assert property (p_opnd_hold) else $error("operand request dropped");
   a_addr_mode: assert property (p_addr_mode) else $error("address operand in compat");
   a_caf: assert property (p_caf) else $error("flag clear ignored");
   a_compat_gt: assert property (p_compat_gt) else $error("greater flag in compat");
   a_to_extended_mode_op: assert property (p_to_extended_mode_op) else $error("mode switch ignored");
   c_mul: cover property (claim && memory_word_buffer == 12'hF05);
   c_norm: cover property (claim && memory_word_buffer == 12'hF09);
   c_ext_done: cover property (done_strobe && mode_ext);
endmodule // xae_core_props

bind xae_core xae_core_props u_props (.clk_sys(clk_sys), .rst_b(rst_b),
   .clear_all_flags_op(clear_all_flags_op), .fetch_strobe(fetch_strobe),
   .memory_word_buffer(memory_word_buffer), .opnd_strobe(opnd_strobe), .claim(claim),
   .opnd_req(opnd_req), .opnd_is_addr(opnd_is_addr), .busy(busy),
   .done_strobe(done_strobe), .greater_flag(greater_flag), .mode_ext(mode_ext));

// ### dv/xae_host_model.sv
`timescale 1ns/1ps
// ****************************
// Host core and memory buffer
// ****************************
module xae_host_model (
   // Clock
   input wire logic               clk_sys,
   // Core answers
   input wire logic               opnd_req,
   input wire logic               done_strobe,
   input wire xae_pkg::xae_work_t work_out,
   // Host requests
   output xae_pkg::xae_work_t     work_in,
   output logic                   fetch_strobe,
   output logic [11:0]            memory_word_buffer,
   output logic                   opnd_strobe,
   output logic [11:0]            opnd_word
);
   import xae_pkg::*;
   int gap = 0;   // Operand delay in cycles
   int poke = -1; // Cycle of a stray fetch while busy
   int lim = 300; // Cycles allowed for completion
   // Idle bus
   initial begin
      work_in = '0;
      fetch_strobe = 1'b0;
      memory_word_buffer = 12'h000;
      opnd_strobe = 1'b0;
      opnd_word = 12'h000;
   end
   // Load the working registers
   task automatic load(input xae_work_t w);
      @(posedge clk_sys);
      #1 work_in = w;
   endtask
   // Fetch, hand over the operand, wait for the end, take results
   task automatic run_op(input logic [11:0] word, input logic [11:0] opnd, output bit ok);
      int n;
      int wt;
      ok = 1'b0;
      wt = 0;
      @(posedge clk_sys);
      #1 fetch_strobe = 1'b1;
      memory_word_buffer = word;
      for (n = 0; n < lim; n++) begin
         @(posedge clk_sys);
         #1;
         fetch_strobe = (n == poke);
         memory_word_buffer = fetch_strobe ? 12'hF09 : ~word; // Plain normalize
         if (done_strobe === 1'b1) begin
            work_in = work_out; // Next fetch only after completion
            ok = 1'b1;
            break;
         end
         if (opnd_req === 1'b1 && opnd_strobe === 1'b0) begin
            wt++;
         end
         opnd_strobe = (opnd_req === 1'b1 && opnd_strobe === 1'b0 && wt > gap);
         opnd_word = opnd_strobe ? opnd : ~opnd;
      end
      fetch_strobe = 1'b0;
   endtask
endmodule // xae_host_model

// ### dv/tb.sv
`timescale 1ns/1ps
// ****************************
// Core testbench
// ****************************
module tb;
   import xae_pkg::*;
   typedef struct packed {xae_work_t w; logic [4:0] t; logic cw; logic ct;} xae_exp_t;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        panel_clear_b = 1'b1;
   logic        clear_all_flags_op = 1'b0;
   logic        fetch_strobe, opnd_strobe, claim, opnd_req, opnd_is_addr;
   logic        busy, done_strobe, greater_flag, mode_ext;
   logic [11:0] memory_word_buffer, opnd_word, m, o;
   logic [4:0]  shift_tally;
   logic [23:0] v, r, q;
   xae_work_t   work_in, work_out, w, s;
   xae_exp_t    e;
   xae_exp_t    expq[$];
   int          err_count = 0;
   int          comparisons = 0;
   int          i, n;
   bit          ok;
   logic        xa = 1'b0; // Operand expected as an address
   // Clock and instances
   always #50 clk_sys = ~clk_sys;
   xae_core uut (.clk_sys(clk_sys), .rst_b(rst_b), .panel_clear_b(panel_clear_b),
      .clear_all_flags_op(clear_all_flags_op), .fetch_strobe(fetch_strobe),
      .memory_word_buffer(memory_word_buffer), .work_in(work_in), .claim(claim),
      .opnd_req(opnd_req), .opnd_is_addr(opnd_is_addr), .opnd_strobe(opnd_strobe),
      .opnd_word(opnd_word), .busy(busy), .done_strobe(done_strobe),
      .work_out(work_out), .greater_flag(greater_flag), .mode_ext(mode_ext),
      .shift_tally(shift_tally));
   xae_host_model host (.clk_sys(clk_sys), .opnd_req(opnd_req), .done_strobe(done_strobe),
      .work_out(work_out), .work_in(work_in), .fetch_strobe(fetch_strobe),
      .memory_word_buffer(memory_word_buffer), .opnd_strobe(opnd_strobe),
      .opnd_word(opnd_word));
   // Reporting and comparison
   task automatic fail(input string msg);
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
   endtask
   task automatic cmp_work(input xae_work_t g, input xae_work_t x);
      comparisons++;
      if (g !== x) fail("work registers");
   endtask
   task automatic cmp_tally(input logic [4:0] g, input logic [4:0] x);
      comparisons++;
      if (g !== x) fail("shift tally");
   endtask
   task automatic cmp_bit(input logic g, input logic x);
      comparisons++;
      if (g !== x) fail("flag");
   endtask
   task automatic finish_test();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic xae_exp_t ex(input xae_work_t x, input logic [4:0] t, input logic cw, ct);
      return {x, t, cw, ct};
   endfunction
   // Normalize reference
   function automatic xae_exp_t norm(input xae_work_t x);
      logic [4:0] t = 5'h00;
      while (x.prim[11] == x.prim[10] && {x.prim, x.low} != 24'hC00000 && t != 5'h1F) begin
         x = x << 1;
         t++;
      end
      return ex(x, t, 1'b1, 1'b1);
   endfunction
   // One operation with its noted result
   task automatic op(input xae_work_t x, input logic [11:0] word, opnd, input xae_exp_t y);
      host.load(x);
      expq.push_back(y);
      host.run_op(word, opnd, ok);
      if (!ok) begin
         fail("no completion");
         finish_test();
      end
   endtask
   // Completion, operand address and hold-off monitor
   always @(posedge clk_sys) begin
      if (opnd_req === 1'b1 && opnd_strobe === 1'b1) cmp_bit(opnd_is_addr, xa);
      if (fetch_strobe === 1'b1 && busy === 1'b1) cmp_bit(claim, 1'b0);
      if (done_strobe === 1'b1) begin
         if (expq.size() == 0) begin
            fail("unexpected completion");
         end else begin
            e = expq.pop_front();
            if (e.cw) cmp_work(work_out, e.w);
            if (e.ct) cmp_tally(shift_tally, e.t);
         end
      end
   end
   // Main sequence
   initial begin
      void'($urandom(12));
      repeat (20) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      cmp_bit(busy, 1'b0);
      cmp_bit(mode_ext, 1'b0);
      // Multiply, prompt and slow operands, refused fetch while busy
      for (i = 0; i < 4; i++) begin
         w = {1'b1, 12'($urandom), 12'($urandom)};
         m = 12'($urandom);
         host.gap = i;
         host.poke = (i == 3) ? 6 : -1;
         r = w.low * m + w.prim;
         op(w, 12'hF05, m, ex({1'b0, r}, 5'h00, 1'b1, 1'b0));
      end
      host.poke = -1;
      // Divide, last one overflows
      for (i = 0; i < 4; i++) begin
         m = 12'($urandom) | 12'h001;
         w = {1'b1, (i == 3) ? m : 12'($urandom) % m, 12'($urandom)};
         v = {w.prim, w.low};
         q = v / m;
         r = v % m;
         s = (i == 3) ? {1'b1, v} : {1'b0, r[11:0], q[11:0]};
         op(w, 12'hF07, m, ex(s, 5'h00, 1'b1, 1'b0));
      end
      // Shifts at counts 0, 31 and random
      for (i = 0; i < 9; i++) begin
         n = (i < 3) ? 0 : (i < 6) ? 31 : $urandom % 32;
         w = 25'($urandom);
         v = {w.prim, w.low};
         case (i % 3)
            0: s = w << (n + 1);
            1: s = {v[23], 24'($signed(v) >>> (n + 1))};
            default: s = {1'b0, v >> (n + 1)};
         endcase
         o = {7'($urandom), 5'(n)};
         op(w, 12'hF0B + 12'(2 * (i % 3)), o, ex(s, 5'h00, 1'b1, 1'b0));
         cmp_bit(greater_flag, 1'b0);
      end
      // Normalize, terminal pattern cases and random
      for (i = 0; i < 4; i++) begin
         w = (i == 0) ? 25'hE00000 : (i == 1) ? 25'hC00000 : 25'($urandom) | 25'h001000;
         op(w, 12'hF09, 12'h000, norm(w));
      end
      // Tally load from operand, then merge into primary
      o = 12'($urandom);
      op(w, 12'hF03, o, ex('0, ~o[4:0], 1'b0, 1'b1));
      w = 25'($urandom);
      op(w, 12'hF21, 12'h000, ex({w.link, w.prim | {7'h00, ~o[4:0]}, w.low}, ~o[4:0], 1'b1,
         1'b1));
      // Foreign words give no completion
      host.lim = 8;
      for (i = 0; i < 3; i++) begin
         host.run_op((i == 0) ? 12'hF04 : (i == 1) ? 12'hD05 : 12'hE05, 12'h000, ok);
         cmp_bit(ok, 1'b0);
      end
      host.lim = 300;
      // Extended mode
      for (i = 0; i < 2; i++) begin
         op(w, 12'hF19, 12'h000, ex('0, 5'h00, 1'b0, 1'b0));
         cmp_bit(mode_ext, 1'b1);
      end
      w = 25'($urandom) | 25'h000010;
      op(w, 12'hF0B, 12'hFE0, ex(w, 5'h00, 1'b1, 1'b0));
      v = {w.prim, w.low};
      op(w, 12'hF0F, 12'h005, ex({1'b0, v >> 5}, 5'h00, 1'b1, 1'b0));
      cmp_bit(greater_flag, v[4]);
      m = 12'($urandom);
      r = w.low * m + w.prim;
      xa = 1'b1;
      op(w, 12'hF05, m, ex({1'b0, r}, 5'h00, 1'b1, 1'b0));
      xa = 1'b0;
      op(w, 12'hF03, 12'h000, ex('0, w.prim[4:0], 1'b0, 1'b1));
      // Flag clear and panel clear force compatible mode
      @(posedge clk_sys);
      #1 clear_all_flags_op = 1'b1;
      @(posedge clk_sys);
      #1 clear_all_flags_op = 1'b0;
      cmp_bit(mode_ext, 1'b0);
      cmp_bit(greater_flag, 1'b0);
      op(w, 12'hF19, 12'h000, ex('0, 5'h00, 1'b0, 1'b0));
      panel_clear_b = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 panel_clear_b = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 cmp_bit(mode_ext, 1'b0);
      if (expq.size() != 0) fail("missing completion");
      finish_test();
   end
endmodule // tb
